/* File: core/hacp_pkg.sv */
package hacp_pkg;
  localparam int          CLK_HZ      = 40_000_000;     // System clock in Hz
  localparam int          BAUD_RATE   = 9600;           // Line rate in baud
  localparam int          BIT_CYCLES  = CLK_HZ / BAUD_RATE; // Cycles per bit, rounded down
  localparam int          VAL_W       = 16;             // Stored value width
  localparam int          NUM_TESTS   = 8;              // Test slots for samples and results
  localparam int          NUM_PORTS   = 2;              // Primary and differential port
  localparam int          KW_W        = 56;             // Keyword holds up to seven characters
  localparam int          NUM_ATTR    = 48;             // Six groups of eight slots
  localparam logic [7:0]  CH_CR       = 8'h0d;          // Carriage return
  localparam logic [7:0]  CH_SPACE    = 8'h20;          // Field separator
  localparam logic [7:0]  CH_DOT      = 8'h2e;          // Decimal point
  localparam logic [7:0]  CH_ZERO     = 8'h30;          // ASCII zero
  localparam logic [7:0]  CH_NINE     = 8'h39;          // ASCII nine
  localparam logic [2:0]  KW_MAX      = 3'h7;           // Keyword length limit
  // Keywords, right aligned ASCII
  localparam logic [KW_W-1:0] KW_ATTRIBUTE_READ_CMD  = 56'h0000000000_5241;
  localparam logic [KW_W-1:0] KW_ATTRIBUTE_WRITE_CMD = 56'h0000000000_5341;
  localparam logic [KW_W-1:0] KW_SAMPLE_CMD          = 56'h00_53414d504c45;
  localparam logic [KW_W-1:0] KW_RESULT_CMD          = 56'h00_524553554c54;
  localparam logic [KW_W-1:0] KW_SPAN_ZERO_COMPUTE_CMD = 56'h434f4d50534554;
  localparam logic [2:0]  NUM_PARAMS  = 3'h6;           // Parameter groups 0..5
  localparam logic [2:0]  PAR_CYC     = 3'h0;           // Cycle-time group
  localparam logic [2:0]  PAR_FREE    = 3'h1;           // Freeness group
  localparam logic [2:0]  ATT_SPAN    = 3'h0;           // Span attribute
  localparam logic [2:0]  ATT_ZERO    = 3'h1;           // Zero attribute
  localparam logic [2:0]  ATT_FILTER  = 3'h2;           // Freeness filter attribute
  localparam logic [15:0] FILTER_MIN  = 16'h0001;
  localparam logic [15:0] FILTER_MAX  = 16'h0009;
  localparam logic [3:0]  FILTER_RST  = 4'h1;           // Filter after reset
  localparam logic [15:0] VAL_SCALE   = 16'h000a;       // Values kept in tenths
  localparam logic [2:0]  DIG_UNITS   = 3'h3;           // Digit position before the point
  localparam logic [2:0]  DIG_LAST    = 3'h4;           // Tenths digit position

  typedef enum logic [1:0] {S_COLLECT, S_EXEC, S_DIGIT, S_SEND} hacp_state_t;

  // Number of attributes in each group
  function automatic logic [3:0] attr_count(input logic [2:0] par);
    case (par)
      3'h0: attr_count = 4'h4;
      3'h1: attr_count = 4'h4;
      3'h2: attr_count = 4'h7;
      3'h3: attr_count = 4'h4;
      3'h4: attr_count = 4'h2;
      3'h5: attr_count = 4'h1;
      default: attr_count = 4'h0;
    endcase
  endfunction : attr_count

  // Decimal weight of each printed digit, in tenths
  function automatic logic [15:0] pow10(input logic [2:0] idx);
    case (idx)
      3'h0: pow10 = 16'h2710;
      3'h1: pow10 = 16'h03e8;
      3'h2: pow10 = 16'h0064;
      3'h3: pow10 = 16'h000a;
      default: pow10 = 16'h0001;
    endcase
  endfunction : pow10
endpackage : hacp_pkg

/* File: core/hacp_uart.sv */
`timescale 1ns/1ps
module hacp_uart #(
  parameter int BIT_CYC = hacp_pkg::BIT_CYCLES   // Clock cycles per bit
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       rxd,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            txd,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  import hacp_pkg::*;
  localparam int CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);   // One bit time
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);   // Centre of start bit

  logic          s1_reg, s2_reg, s3_reg, filt_reg, filt_next; // Pin synchroniser
  logic          rxb_reg, rxb_next;                           // Receiver busy
  logic [CW-1:0] rxc_reg, rxc_next;                           // Receive bit timer
  logic [3:0]    rxi_reg, rxi_next;                           // Receive bit index
  logic [7:0]    rxs_reg, rxs_next;                           // Receive shifter
  logic          rxv_next;
  logic [7:0]    rxd_next;
  logic          txb_reg, txb_next;                           // Transmitter busy
  logic [CW-1:0] txc_reg, txc_next;
  logic [3:0]    txi_reg, txi_next;
  logic [8:0]    txs_reg, txs_next;                           // Data then stop bit
  logic          txd_next;

  assign tx_ready = !txb_reg;

  // Next state for both directions
  always_comb begin
    // Level changes only once the second and third stages agree
    filt_next = (s2_reg == s3_reg) ? s3_reg : filt_reg;
    {rxb_next, rxc_next, rxi_next, rxs_next} = {rxb_reg, rxc_reg, rxi_reg, rxs_reg};
    rxv_next  = 1'b0;
    rxd_next  = rx_data;
    if (!rxb_reg) begin
      if (!filt_reg) begin // Start edge seen
        rxb_next = 1'b1;
        rxc_next = HALF;
        rxi_next = 4'h0;
      end
    end else if (rxc_reg != '0) begin
      rxc_next = rxc_reg - 1'b1;
    end else begin
      rxc_next = FULL;
      if (rxi_reg == 4'h0) begin
        rxb_next = !filt_reg; // A glitch, not a start bit, is dropped
        rxi_next = 4'h1;
      end else if (rxi_reg <= 4'h8) begin // Eight data bits, LSB first
        rxs_next = {filt_reg, rxs_reg[7:1]};
        rxi_next = rxi_reg + 4'h1;
      end else begin // One stop bit, no parity; framing errors lose the byte
        rxb_next = 1'b0;
        rxv_next = filt_reg;
        if (filt_reg) begin
          rxd_next = rxs_reg;
        end
      end
    end
    {txb_next, txc_next, txi_next, txs_next, txd_next} = {txb_reg, txc_reg, txi_reg, txs_reg, txd};
    if (!txb_reg) begin
      if (tx_valid) begin // Start bit goes out at once
        txb_next = 1'b1;
        txc_next = FULL;
        txi_next = 4'h0;
        txs_next = {1'b1, tx_data};
        txd_next = 1'b0;
      end
    end else if (txc_reg != '0) begin
      txc_next = txc_reg - 1'b1;
    end else if (txi_reg == 4'h9) begin
      txb_next = 1'b0; // Stop bit time over
    end else begin
      txc_next = FULL;
      txi_next = txi_reg + 4'h1;
      txd_next = txs_reg[0];
      txs_next = {1'b1, txs_reg[8:1]};
    end
  end

  // Registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      {s1_reg, s2_reg, s3_reg, filt_reg} <= 4'hf;
      {rxb_reg, rxc_reg, rxi_reg, rxs_reg} <= '0;
      {rx_valid, rx_data} <= '0;
      {txb_reg, txc_reg, txi_reg, txs_reg} <= '0;
      txd <= 1'b1; // Line idles high
    end else begin
      {s1_reg, s2_reg, s3_reg, filt_reg} <= {rxd, s1_reg, s2_reg, filt_next};
      {rxb_reg, rxc_reg, rxi_reg, rxs_reg} <= {rxb_next, rxc_next, rxi_next, rxs_next};
      {rx_valid, rx_data} <= {rxv_next, rxd_next};
      {txb_reg, txc_reg, txi_reg, txs_reg, txd} <= {txb_next, txc_next, txi_next, txs_next, txd_next};
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_tx_start; tx_valid && tx_ready |=> (!txd && !tx_ready) [*8]; endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit not driven");
  property p_rx_stop; rx_valid |-> $past(filt_reg) && !$past(rxb_next); endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("byte without stop bit");
  property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive strobe too long");
endmodule : hacp_uart

/* File: core/hacp_cmd_parser.sv */
`timescale 1ns/1ps
module hacp_cmd_parser #(
  parameter int BIT_CYC = hacp_pkg::BIT_CYCLES,  // Cycles per serial bit
  parameter int N_TESTS = hacp_pkg::NUM_TESTS    // Test slots
) (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic                      rx_pri,       // Primary port receive pin
  output logic                           tx_pri,       // Primary port transmit pin
  input  wire logic                      rx_diff,      // Differential port receive pair, after receiver
  output logic                           tx_diff,      // Differential port transmit, to driver
  input  wire logic [hacp_pkg::VAL_W-1:0] cycle_time,  // Current measured cycle time
  output logic [hacp_pkg::VAL_W-1:0]     time_span,    // Cycle-time span setting
  output logic [hacp_pkg::VAL_W-1:0]     time_zero,    // Cycle-time zero setting
  output logic [3:0]                     filter_len    // Freeness averaging depth
);
  import hacp_pkg::*;
  localparam int TW = $clog2(N_TESTS);

  logic [NUM_PORTS-1:0] rx_pins, tx_pins, rxv, txv, txr; // Per-port handshakes
  logic [7:0]           rxb [NUM_PORTS];                 // Received bytes
  hacp_state_t          state_reg, state_next;
  logic                 act_reg, act_next;               // A line is being collected
  logic                 port_reg, port_next;             // Port that owns the line
  logic [KW_W-1:0]      kw_reg, kw_next;                 // Keyword characters
  logic [2:0]           kwl_reg, kwl_next;
  logic [1:0]           fidx_reg, fidx_next;             // Current field
  logic                 ne_reg, ne_next;                 // Current field has characters
  logic                 err_reg, err_next;               // Line already malformed
  logic                 fm_reg, fm_next;                 // Past the decimal point
  logic                 fd_reg, fd_next;                 // Tenths digit taken
  logic [VAL_W-1:0]     ni_reg [3], ni_next [3];         // Integer part per argument
  logic [3:0]           nf_reg [3], nf_next [3];         // Tenths per argument
  logic [VAL_W-1:0]     rem_reg, rem_next;               // Value left to print
  logic [2:0]           pidx_reg, pidx_next;             // Digit position
  logic [3:0]           dig_reg, dig_next;
  logic                 st_reg, st_next;                 // A digit was printed
  logic [7:0]           chr_reg, chr_next;               // Character being sent
  logic [3:0]           flen_reg, flen_next;
  logic [VAL_W-1:0]     attr_mem [NUM_ATTR];             // Attribute settings
  logic [VAL_W-1:0]     samp_mem [N_TESTS];              // Cycle-time samples
  logic [VAL_W-1:0]     res_mem  [N_TESTS];              // Lab results
  logic                 sel, acc, attr_we, samp_we, res_we, comp_we, rd_ok;
  logic [7:0]           ch;
  logic [5:0]           aidx, attr_wa;
  logic [VAL_W-1:0]     attr_wd;
  logic [VAL_W-1:0]     fx [3];                          // Arguments in tenths
  logic [TW-1:0]        tidx;
  logic [2:0]           nfld;
  logic                 addr_ok, test_ok, val_ok;

  assign rx_pins = {rx_diff, rx_pri};
  assign tx_pri  = tx_pins[0];
  assign tx_diff = tx_pins[1];
  assign time_span  = attr_mem[{PAR_CYC, ATT_SPAN}];
  assign time_zero  = attr_mem[{PAR_CYC, ATT_ZERO}];
  assign filter_len = flen_reg;

  // One serial engine per port
  genvar g;
  for (g = 0; g < NUM_PORTS; g++) begin : g_port
    hacp_uart #(.BIT_CYC(BIT_CYC)) u_uart (
      .clock    (clock),
      .rstn     (rstn),
      .rxd      (rx_pins[g]),
      .tx_valid (txv[g]),
      .tx_data  (chr_reg),
      .txd      (tx_pins[g]),
      .tx_ready (txr[g]),
      .rx_valid (rxv[g]),
      .rx_data  (rxb[g])
    );
    // Answer only on the port that sent the line
    assign txv[g] = (state_reg == S_SEND) && (port_reg == g);
  end

  // Byte intake and decode of a complete line
  always_comb begin
    // The primary port wins a tie; the other port's byte is lost while a line is open
    sel = !(rxv[0] && (!act_reg || !port_reg));
    acc = (state_reg == S_COLLECT) && rxv[sel] && (!act_reg || port_reg == sel);
    ch  = rxb[sel];
    for (int k = 0; k < 3; k++) begin
      fx[k] = VAL_W'(ni_reg[k] * VAL_SCALE + VAL_W'(nf_reg[k]));
    end
    nfld    = {1'b0, fidx_reg} + {2'b0, ne_reg};
    aidx    = {ni_reg[0][2:0], ni_reg[1][2:0]};
    addr_ok = (ni_reg[0] < VAL_W'(NUM_PARAMS)) && (ni_reg[1] < VAL_W'(attr_count(ni_reg[0][2:0])));
    val_ok  = (aidx != {PAR_FREE, ATT_FILTER}) ||
              (nf_reg[2] == 4'h0 && ni_reg[2] >= FILTER_MIN && ni_reg[2] <= FILTER_MAX);
    test_ok = (ni_reg[0] != '0) && (ni_reg[0] <= VAL_W'(N_TESTS));
    tidx    = TW'(ni_reg[0] - 16'h0001);
    {rd_ok, attr_we, samp_we, res_we, comp_we} = '0;
    attr_wa = aidx;
    attr_wd = fx[2];
    if (state_reg == S_EXEC && !err_reg) begin
      case (kw_reg)
        KW_ATTRIBUTE_READ_CMD:    rd_ok   = (nfld == 3'h3) && addr_ok;
        KW_ATTRIBUTE_WRITE_CMD:   attr_we = (nfld == 3'h4) && addr_ok && val_ok;
        KW_SAMPLE_CMD:            samp_we = (nfld == 3'h2) && test_ok;
        KW_RESULT_CMD:            res_we  = (nfld == 3'h3) && test_ok;
        KW_SPAN_ZERO_COMPUTE_CMD: comp_we = (nfld == 3'h3);
        default: ;                                                     // Unknown keyword dropped
      endcase
    end
  end

  // Line parser and reply formatter
  always_comb begin
    state_next = state_reg;
    {act_next, port_next, kw_next, kwl_next} = {act_reg, port_reg, kw_reg, kwl_reg};
    {fidx_next, ne_next, err_next, fm_next, fd_next} = {fidx_reg, ne_reg, err_reg, fm_reg, fd_reg};
    ni_next = ni_reg;
    nf_next = nf_reg;
    {rem_next, pidx_next, dig_next, st_next, chr_next} = {rem_reg, pidx_reg, dig_reg, st_reg, chr_reg};
    flen_next = (attr_we && attr_wa == {PAR_FREE, ATT_FILTER}) ? ni_reg[2][3:0] : flen_reg;
    case (state_reg)
      S_COLLECT: begin
        if (acc) begin
          act_next  = 1'b1;
          port_next = act_reg ? port_reg : sel;
          if (ch == CH_CR) begin
            state_next = S_EXEC;
          end else if (ch == CH_SPACE) begin
            if (ne_reg) begin // Repeated spaces count once
              err_next  = err_reg || (fidx_reg == 2'h3);
              fidx_next = fidx_reg + 2'h1;
              {ne_next, fm_next, fd_next} = 3'b000;
            end
          end else if (fidx_reg == 2'h0) begin
            ne_next  = 1'b1;
            err_next = err_reg || (kwl_reg == KW_MAX);
            kw_next  = {kw_reg[KW_W-9:0], ch};
            kwl_next = kwl_reg + 3'h1;
          end else begin
            ne_next = 1'b1;
            if (ch >= CH_ZERO && ch <= CH_NINE) begin
              if (!fm_reg) begin // Overlong numbers wrap at the value width
                ni_next[fidx_reg - 2'h1] = VAL_W'(ni_reg[fidx_reg - 2'h1] * VAL_SCALE + VAL_W'(ch - CH_ZERO));
              end else if (!fd_reg) begin // Digits past tenths are truncated
                nf_next[fidx_reg - 2'h1] = 4'(ch - CH_ZERO);
                fd_next = 1'b1;
              end
            end else if (ch == CH_DOT && !fm_reg) begin
              fm_next = 1'b1;
            end else begin
              err_next = 1'b1;
            end
          end
        end
      end
      S_EXEC: begin
        // Clear the line whatever the outcome
        {act_next, kw_next, kwl_next, fidx_next, ne_next, err_next, fm_next, fd_next} = '0;
        ni_next = '{default: '0};
        nf_next = '{default: '0};
        state_next = rd_ok ? S_DIGIT : S_COLLECT;
        rem_next   = attr_mem[aidx];
        {pidx_next, dig_next, st_next} = '0;
      end
      S_DIGIT: begin
        // Repeated subtraction: slow but far faster than the line
        if (rem_reg >= pow10(pidx_reg)) begin
          rem_next = rem_reg - pow10(pidx_reg);
          dig_next = dig_reg + 4'h1;
        end else if (dig_reg != 4'h0 || st_reg || pidx_reg >= DIG_UNITS) begin
          chr_next   = CH_ZERO + {4'h0, dig_reg};
          st_next    = 1'b1;
          state_next = S_SEND;
        end else begin // Leading zero suppressed
          pidx_next = pidx_reg + 3'h1;
        end
      end
      S_SEND: begin
        if (txr[port_reg]) begin
          if (chr_reg == CH_CR) begin
            state_next = S_COLLECT;
          end else if (pidx_reg == DIG_UNITS && chr_reg != CH_DOT) begin
            chr_next = CH_DOT;
          end else if (pidx_reg == DIG_LAST) begin
            chr_next = CH_CR;
          end else begin
            pidx_next  = pidx_reg + 3'h1;
            dig_next   = 4'h0;
            state_next = S_DIGIT;
          end
        end
      end
      default: state_next = S_COLLECT;
    endcase
  end

  // Parser registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= S_COLLECT;
      {act_reg, port_reg, kw_reg, kwl_reg, fidx_reg, ne_reg, err_reg, fm_reg, fd_reg} <= '0;
      ni_reg <= '{default: '0};
      nf_reg <= '{default: '0};
      {rem_reg, pidx_reg, dig_reg, st_reg, chr_reg} <= '0;
      flen_reg <= FILTER_RST;
    end else begin
      state_reg <= state_next;
      {act_reg, port_reg, kw_reg, kwl_reg} <= {act_next, port_next, kw_next, kwl_next};
      {fidx_reg, ne_reg, err_reg, fm_reg, fd_reg} <= {fidx_next, ne_next, err_next, fm_next, fd_next};
      ni_reg <= ni_next;
      nf_reg <= nf_next;
      {rem_reg, pidx_reg, dig_reg, st_reg, chr_reg} <= {rem_next, pidx_next, dig_next, st_next, chr_next};
      flen_reg <= flen_next;
    end
  end

  // Settings store; all writes come from a checked line only
  always_ff @(posedge clock) begin
    if (!rstn) begin
      attr_mem <= '{default: '0};
      attr_mem[{PAR_FREE, ATT_FILTER}] <= VAL_W'(FILTER_RST) * VAL_SCALE;
      samp_mem <= '{default: '0};
      res_mem  <= '{default: '0};
    end else begin
      if (attr_we) begin
        attr_mem[attr_wa] <= attr_wd;
      end
      if (samp_we) begin
        samp_mem[tidx] <= cycle_time;
      end
      if (res_we) begin
        res_mem[tidx] <= fx[1];
      end
      if (comp_we) begin // Two-point fit from tests 1 and 2
        attr_mem[{PAR_FREE, ATT_SPAN}] <= fx[0];
        attr_mem[{PAR_FREE, ATT_ZERO}] <= fx[1];
        attr_mem[{PAR_CYC, ATT_SPAN}]  <= samp_mem[1] - samp_mem[0];
        attr_mem[{PAR_CYC, ATT_ZERO}]  <= (res_mem[0] <= res_mem[1]) ? samp_mem[0] : samp_mem[1];
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_cr_exec; acc && ch == CH_CR |=> state_reg == S_EXEC; endproperty
  a_cr_exec: assert property (p_cr_exec) else $error("CR did not end line");
  property p_space_field; acc && ch == CH_SPACE && ne_reg |=> fidx_reg == $past(fidx_reg) + 2'h1; endproperty
  a_space_field: assert property (p_space_field) else $error("space did not advance");
  property p_filter_range; flen_reg >= 4'h1 && flen_reg <= 4'h9; endproperty
  a_filter_range: assert property (p_filter_range) else $error("filter out of range");
  property p_no_write_on_err; err_reg |-> !attr_we && !samp_we && !res_we && !comp_we && !rd_ok; endproperty
  a_no_write_on_err: assert property (p_no_write_on_err) else $error("bad line acted on");
  property p_sample_capture; samp_we |=> samp_mem[$past(tidx)] == $past(cycle_time); endproperty
  a_sample_capture: assert property (p_sample_capture) else $error("sample not captured");
  property p_reply_port; state_reg == S_SEND |-> txv[port_reg] && !txv[!port_reg]; endproperty
  a_reply_port: assert property (p_reply_port) else $error("reply on wrong port");
  property p_read_reply; rd_ok |=> state_reg == S_DIGIT ##1 state_reg inside {S_DIGIT, S_SEND}; endproperty
  a_read_reply: assert property (p_read_reply) else $error("read gave no reply");
  property p_attr_write; attr_we |=> attr_mem[$past(attr_wa)] == $past(attr_wd); endproperty
  a_attr_write: assert property (p_attr_write) else $error("attribute not stored");
endmodule : hacp_cmd_parser

/* File: testbench/hacp_host_model.sv */
`timescale 1ns/1ps
// Host end of one serial port: sends ASCII lines, reads a reply
module hacp_host_model #(
  parameter int BIT_CYC = 16  // Cycles per bit, matches the dut
) (
  input  wire logic clock,
  input  wire logic txd,      // Dut transmit line
  output logic      rxd       // Dut receive line
);
  // Line idles high between characters
  initial rxd = 1'b1;
  // One 8N1 character, LSB first, then a short idle gap
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock) #1 rxd = f[i];
      repeat (BIT_CYC-1) @(posedge clock);
    end
    repeat (3) @(posedge clock);
  endtask : send_byte
  // Fields go as the caller spaced them, then CR closes the line
  task automatic send_line(input string s);
    foreach (s[i]) send_byte(s[i]);
    send_byte(8'h0d);
  endtask : send_line
  // Four reply bytes, first one in the top byte; a bounded wait per start bit
  task automatic recv_word(output logic [31:0] w);
    int         n;
    logic [7:0] b;
    w = 32'h0;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      while (txd !== 1'b0 && n < 3200) begin
        @(posedge clock);
        n++;
      end
      repeat (BIT_CYC/2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clock);
        b[i] = txd;
      end
      repeat (BIT_CYC) @(posedge clock); // Centre of the stop bit
      w = {w[23:0], b};
    end
  endtask : recv_word
endmodule : hacp_host_model

/* File: testbench/host_ascii_command_parser_bench.sv */
`timescale 1ns/1ps
module host_ascii_command_parser_bench;
  import hacp_pkg::*;
  localparam int    BC = 16;  // Short bit time keeps the run brief
  logic             clock, rstn, rx_pri, tx_pri, rx_diff, tx_diff;
  logic [VAL_W-1:0] cycle_time, time_span, time_zero;
  logic [3:0]       filter_len;
  logic [31:0]      word;     // Last reply, four characters
  int               errors, checked;
  // Two-letter and seven-letter keywords go as octal character codes
  string            bad [5] = '{"\123\101 1 2 10", "\123\101 1 2 0", "\123\101 6 0 5", "\123\101 1 4 5", "XX 1 2 5"};

  hacp_cmd_parser #(.BIT_CYC(BC), .N_TESTS(8)) dut_u (.clock(clock), .rstn(rstn), .rx_pri(rx_pri),
    .tx_pri(tx_pri), .rx_diff(rx_diff), .tx_diff(tx_diff), .cycle_time(cycle_time),
    .time_span(time_span), .time_zero(time_zero), .filter_len(filter_len));
  hacp_host_model #(.BIT_CYC(BC)) pri_u (.clock(clock), .txd(tx_pri), .rxd(rx_pri));
  hacp_host_model #(.BIT_CYC(BC)) dif_u (.clock(clock), .txd(tx_diff), .rxd(rx_diff));

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // Let the parser finish executing a line
  task automatic gap();
    repeat (40) @(posedge clock);
    #1; // Look at outputs once the edge has settled
  endtask : gap
  task automatic t_reset();
    check("tx_pri idle", {31'h0, tx_pri}, 32'h1);
    check("tx_diff idle", {31'h0, tx_diff}, 32'h1);
    check("span", {16'h0, time_span}, 32'h0);
    check("filter", {28'h0, filter_len}, 32'h1);
  endtask : t_reset
  // Reply must come back on the asking port, "1.0" CR
  task automatic t_read_pri();
    fork
      pri_u.send_line("\122\101 1 2");
      pri_u.recv_word(word);
    join
    check("read pri", word, 32'h312e300d);
  endtask : t_read_pri
  task automatic t_write_diff();
    dif_u.send_line("\123\101 1 2 5");
    gap();
    check("filter write", {28'h0, filter_len}, 32'h5);
    fork
      dif_u.send_line("\122\101 1 2");
      dif_u.recv_word(word);
    join
    check("read diff", word, 32'h352e300d);
  endtask : t_write_diff
  // Bad lines leave the filter alone; a legal span write still lands
  task automatic t_refuse();
    foreach (bad[i]) pri_u.send_line(bad[i]);
    gap();
    check("filter kept", {28'h0, filter_len}, 32'h5);
    pri_u.send_line("\123\101 0 0 12.5");
    gap();
    check("span write", {16'h0, time_span}, 32'h7d);
  endtask : t_refuse
  // Two samples, two results; test 2 has the lower result
  task automatic t_calib();
    @(posedge clock) #1 cycle_time = 16'h0064;
    pri_u.send_line("SAMPLE 1");
    @(posedge clock) #1 cycle_time = 16'h0096;
    pri_u.send_line("SAMPLE 2");
    pri_u.send_line("RESULT 1 50.0");
    pri_u.send_line("RESULT 2 40.0");
    pri_u.send_line("\103\117\115\120\123\105\124 100.0 10.0");
    gap();
    check("comp span", {16'h0, time_span}, 32'h32);
    check("comp zero", {16'h0, time_zero}, 32'h96);
  endtask : t_calib

  // Clock at 40 MHz
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    errors = 0;
    checked = 0;
    rstn = 1'b0;
    cycle_time = 16'h0;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (5) @(posedge clock);
    t_reset();
    t_read_pri();
    t_write_diff();
    t_refuse();
    t_calib();
    give_verdict();
  end
endmodule : host_ascii_command_parser_bench
